// [rtl/csp_device.sv]
`timescale 1ns/100ps
module csp_device
  import csp_pkg::*;
#(
  parameter int NUM_BLOCKS = CSP_NUM_BLOCKS
) (
  // system clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // serial link, device end
  csp_if.dev link,
  // fast enable pin and lo mode strap
  input wire logic fast_enable_pin_in,
  input wire logic polyphase_mode_in,
  // gated block enables
  output logic [NUM_BLOCKS-1:0] block_en_out,
  // lo output control
  output logic [1:0] lo_out_drive_level_out,
  output csp_lo_rate_t lo_output_pos_rate_out,
  output logic lo_out_clean_single_out,
  // balun tuning
  output logic [3:0] balun_input_cap_sel_out,
  output logic [3:0] balun_output_cap_sel_out,
  // linearity trim
  output logic [6:0] linearity_resistor_sel_out,
  output logic [5:0] linearity_capacitor_sel_out
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain state

  logic [CSP_CNT_W-1:0] cnt_reg;
  logic [7:0] hdr_reg;
  logic [CSP_DATA_W-1:0] data_sh_reg;
  logic [CSP_DATA_W-1:0] cfg_reg [CSP_NUM_REGS];
  logic clr_reg;
  logic [CSP_CNT_W-1:0] data_idx;
  logic [3:0] bit_pos;
  logic [2:0] idx;
  logic in_data;
  logic is_read;
  logic wr_bit_ok;
  logic [CSP_DATA_W-1:0] rd_word;

  // header complete once eight edges seen
  assign in_data = (cnt_reg >= CSP_HDR_BITS);
  assign data_idx = cnt_reg - CSP_HDR_BITS;
  assign bit_pos = 4'(CSP_DATA_BITS - 6'h01 - data_idx);
  assign idx = csp_reg_index(hdr_reg[7:1]);
  assign is_read = (hdr_reg[0] == CSP_DIR_READ);
  assign wr_bit_ok = !link.cs_n && in_data && !is_read && (idx != CSP_IDX_NONE);
  assign rd_word = (idx == CSP_IDX_NONE) ? '0 : cfg_reg[idx];

  // frame position, cleared whenever select is high
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_reg <= '0;
    end else if (cnt_reg != CSP_CNT_MAX) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  // address and direction, MSB first
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      hdr_reg <= '0;
    end else if (!in_data) begin
      hdr_reg <= {hdr_reg[6:0], link.sdio};
    end
  end

  // history of the most recent data bits
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      data_sh_reg <= '0;
    end else if (in_data) begin
      data_sh_reg <= {data_sh_reg[CSP_DATA_W-2:0], link.sdio};
    end
  end

  // register file, written bit by bit for the first 16 data bits, then as a whole word from the history
  always_ff @(posedge link.sclk or posedge clr_reg) begin
    if (clr_reg) begin
      for (int i = 0; i < CSP_NUM_REGS; i++) begin
        cfg_reg[i] <= csp_reset_value(3'(i));
      end
    end else if (wr_bit_ok) begin
      if (data_idx < CSP_DATA_BITS) begin
        cfg_reg[idx][bit_pos] <= link.sdio;
      end else begin
        cfg_reg[idx] <= {data_sh_reg[CSP_DATA_W-2:0], link.sdio};
      end
    end
  end

  // read data launched on the falling edge, released with select
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      link.dev_sdio_oe_n <= 1'b1;
      link.dev_sdio_out <= 1'b0;
    end else if (in_data && is_read) begin
      link.dev_sdio_oe_n <= 1'b0;
      if (data_idx < CSP_DATA_BITS) begin
        link.dev_sdio_out <= rd_word[bit_pos];
      end else begin
        link.dev_sdio_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain

  logic cs_n_s;
  logic fast_en_s;
  logic poly_s;
  logic [CSP_DATA_W-1:0] shadow_reg [CSP_NUM_REGS];
  logic [CSP_DATA_W-1:0] en_w;
  logic [CSP_DATA_W-1:0] mask_w;
  logic [CSP_DATA_W-1:0] lo_w;
  logic [CSP_DATA_W-1:0] bal_w;
  logic [CSP_DATA_W-1:0] lin_w;
  csp_lo_rate_t rate_next;

  csp_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in({link.cs_n, fast_enable_pin_in, polyphase_mode_in}),
    .q_out({cs_n_s, fast_en_s, poly_s})
  );

  // clears the link-side register file during reset
  always_ff @(posedge clk_in) begin
    clr_reg <= !rst_n_in;
  end

  // register words cross only while select is high and the link is quiet
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CSP_NUM_REGS; i++) begin
        shadow_reg[i] <= csp_reset_value(3'(i));
      end
    end else if (cs_n_s) begin
      for (int i = 0; i < CSP_NUM_REGS; i++) begin
        shadow_reg[i] <= cfg_reg[i];
      end
    end
  end

  assign en_w = shadow_reg[CSP_IDX_BLOCK_ENABLES];
  assign mask_w = shadow_reg[CSP_IDX_FAST_ENABLE_MASK];
  assign lo_w = shadow_reg[CSP_IDX_LO_DIVIDER_AND_DRIVE];
  assign bal_w = shadow_reg[CSP_IDX_BALUN_TUNING];
  assign lin_w = shadow_reg[CSP_IDX_LINEARITY_TRIM];

  // lo output rate selection
  always_comb begin
    rate_next = CSP_LO_OFF;
    if (poly_s) begin
      if (mask_w[CSP_POS_LO_SINGLE_RATE]) begin
        rate_next = CSP_LO_SINGLE;
      end
    end else if (lo_w[CSP_POS_LO_HALVE]) begin
      rate_next = CSP_LO_SINGLE;
    end else if (en_w[CSP_POS_LO_DOUBLE_RATE]) begin
      rate_next = CSP_LO_DOUBLE;
    end
  end

  // gated enables
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      block_en_out <= '0;
    end else begin
      block_en_out <= en_w[NUM_BLOCKS-1:0] &
                      (~mask_w[NUM_BLOCKS-1:0] | {NUM_BLOCKS{fast_en_s}});
    end
  end

  // lo output controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lo_out_drive_level_out <= 2'h0;
      lo_output_pos_rate_out <= CSP_LO_OFF;
      lo_out_clean_single_out <= 1'b0;
    end else begin
      lo_out_drive_level_out <= lo_w[CSP_POS_LO_DRIVE_LEVEL +: 2];
      lo_output_pos_rate_out <= rate_next;
      lo_out_clean_single_out <= !poly_s && en_w[CSP_POS_LO_SINGLE_RATE];
    end
  end

  // balun and linearity fields
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      balun_input_cap_sel_out <= 4'h0;
      balun_output_cap_sel_out <= 4'h0;
      linearity_resistor_sel_out <= 7'h00;
      linearity_capacitor_sel_out <= 6'h00;
    end else begin
      balun_input_cap_sel_out <= bal_w[CSP_POS_BALUN_CIN +: 4];
      balun_output_cap_sel_out <= bal_w[CSP_POS_BALUN_COUT +: 4];
      linearity_resistor_sel_out <= lin_w[CSP_POS_LIN_RES +: 7];
      linearity_capacitor_sel_out <= lin_w[CSP_POS_LIN_CAP +: 6];
    end
  end

endmodule

// [rtl/csp_pkg.sv]
package csp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam int CSP_ADDR_W = 7;
  localparam int CSP_DATA_W = 16;
  localparam int CSP_NUM_BLOCKS = 11;
  localparam int CSP_NUM_REGS = 5;
  localparam int CSP_CNT_W = 6;
  localparam logic [5:0] CSP_HDR_BITS = 6'h08;
  localparam logic [5:0] CSP_DATA_BITS = 6'h10;
  localparam logic [5:0] CSP_CNT_MAX = 6'h3f;
  localparam logic CSP_DIR_READ = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets and storage slots
  localparam logic [6:0] CSP_OFS_BLOCK_ENABLES = 7'h01;
  localparam logic [6:0] CSP_OFS_FAST_ENABLE_MASK = 7'h10;
  localparam logic [6:0] CSP_OFS_LO_DIVIDER_AND_DRIVE = 7'h22;
  localparam logic [6:0] CSP_OFS_BALUN_TUNING = 7'h30;
  localparam logic [6:0] CSP_OFS_LINEARITY_TRIM = 7'h31;
  localparam logic [2:0] CSP_IDX_BLOCK_ENABLES = 3'h0;
  localparam logic [2:0] CSP_IDX_FAST_ENABLE_MASK = 3'h1;
  localparam logic [2:0] CSP_IDX_LO_DIVIDER_AND_DRIVE = 3'h2;
  localparam logic [2:0] CSP_IDX_BALUN_TUNING = 3'h3;
  localparam logic [2:0] CSP_IDX_LINEARITY_TRIM = 3'h4;
  localparam logic [2:0] CSP_IDX_NONE = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [15:0] CSP_RST_BLOCK_ENABLES = 16'h0000;
  localparam logic [15:0] CSP_RST_FAST_ENABLE_MASK = 16'h0000;
  localparam logic [15:0] CSP_RST_LO_DIVIDER_AND_DRIVE = 16'h0000;
  localparam logic [15:0] CSP_RST_BALUN_TUNING = 16'h0000;
  localparam logic [15:0] CSP_RST_LINEARITY_TRIM = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CSP_POS_LO_SINGLE_RATE = 7;
  localparam int CSP_POS_LO_DOUBLE_RATE = 8;
  localparam int CSP_POS_LO_HALVE = 5;
  localparam int CSP_POS_LO_DRIVE_LEVEL = 6;
  localparam int CSP_POS_BALUN_CIN = 0;
  localparam int CSP_POS_BALUN_COUT = 4;
  localparam int CSP_POS_LIN_CAP = 0;
  localparam int CSP_POS_LIN_RES = 6;

  ////////////////////////////////////////////////////////////////////////////
  // host timing in clk_in cycles
  localparam int CSP_SCLK_HALF = 4;
  localparam int CSP_HOLD_CYCLES = 16;

  typedef enum logic [1:0] {
    CSP_LO_OFF = 2'h0,
    CSP_LO_SINGLE = 2'h1,
    CSP_LO_DOUBLE = 2'h2
  } csp_lo_rate_t;

  typedef enum logic [1:0] {
    CSP_H_IDLE = 2'h0,
    CSP_H_SETUP = 2'h1,
    CSP_H_SHIFT = 2'h3,
    CSP_H_HOLD = 2'h2
  } csp_host_state_t;

  function automatic logic [2:0] csp_reg_index(input logic [6:0] addr);
    case (addr)
      CSP_OFS_BLOCK_ENABLES: csp_reg_index = CSP_IDX_BLOCK_ENABLES;
      CSP_OFS_FAST_ENABLE_MASK: csp_reg_index = CSP_IDX_FAST_ENABLE_MASK;
      CSP_OFS_LO_DIVIDER_AND_DRIVE: csp_reg_index = CSP_IDX_LO_DIVIDER_AND_DRIVE;
      CSP_OFS_BALUN_TUNING: csp_reg_index = CSP_IDX_BALUN_TUNING;
      CSP_OFS_LINEARITY_TRIM: csp_reg_index = CSP_IDX_LINEARITY_TRIM;
      default: csp_reg_index = CSP_IDX_NONE;
    endcase
  endfunction

  function automatic logic [15:0] csp_reset_value(input logic [2:0] idx);
    case (idx)
      CSP_IDX_BLOCK_ENABLES: csp_reset_value = CSP_RST_BLOCK_ENABLES;
      CSP_IDX_FAST_ENABLE_MASK: csp_reset_value = CSP_RST_FAST_ENABLE_MASK;
      CSP_IDX_LO_DIVIDER_AND_DRIVE: csp_reset_value = CSP_RST_LO_DIVIDER_AND_DRIVE;
      CSP_IDX_BALUN_TUNING: csp_reset_value = CSP_RST_BALUN_TUNING;
      default: csp_reset_value = CSP_RST_LINEARITY_TRIM;
    endcase
  endfunction

endpackage

// [rtl/csp_if.sv]
`timescale 1ns/100ps
interface csp_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_out;
  logic host_sdio_oe_n;
  logic dev_sdio_out;
  logic dev_sdio_oe_n;
  logic sdio;

  // shared data line, pulled high when nobody drives
  assign sdio = !host_sdio_oe_n ? host_sdio_out :
                (!dev_sdio_oe_n ? dev_sdio_out : 1'b1);

  modport host (
    output sclk,
    output cs_n,
    output host_sdio_out,
    output host_sdio_oe_n,
    input sdio
  );

  modport dev (
    input sclk,
    input cs_n,
    input sdio,
    output dev_sdio_out,
    output dev_sdio_oe_n
  );
endinterface

// [rtl/csp_sync.sv]
`timescale 1ns/100ps
module csp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// [rtl/csp_host.sv]
`timescale 1ns/100ps
module csp_host
  import csp_pkg::*;
#(
  parameter int HALF = CSP_SCLK_HALF,
  parameter int HOLD = CSP_HOLD_CYCLES
) (
  // system clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // serial link, host end
  csp_if.host link,
  // command
  input wire logic start_in,
  input wire logic read_in,
  input wire logic [CSP_ADDR_W-1:0] addr_in,
  input wire logic [CSP_DATA_W-1:0] wdata_in,
  input wire logic [5:0] data_bits_in,
  // status and answer
  output logic busy_out,
  output logic done_out,
  output logic [CSP_DATA_W-1:0] rdata_out
);

  csp_host_state_t state_reg;
  logic [7:0] div_reg;
  logic [6:0] bit_reg;
  logic [6:0] last_bit;
  logic [6:0] next_bit;
  logic sclk_reg;
  logic [7:0] hdr_reg;
  logic [CSP_DATA_W-1:0] wd_reg;
  logic [5:0] n_reg;
  logic sdio_s;
  logic half_end;
  logic fall_evt;

  // value of frame bit b: header, then data padded so the last 16 are wd
  function automatic logic tx_bit(input logic [7:0] hdr, input logic [15:0] wd,
                                  input logic [5:0] n, input logic [6:0] b);
    logic [6:0] j;
    logic [6:0] pad;
    j = b - 7'h08;
    pad = (n > CSP_DATA_BITS) ? 7'(n - CSP_DATA_BITS) : 7'h00;
    if (b < 7'h08) begin
      tx_bit = hdr[3'(7'h07 - b)];
    end else if (j < pad) begin
      tx_bit = 1'b0;
    end else begin
      tx_bit = wd[4'(7'h0f - (j - pad))];
    end
  endfunction

  csp_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(link.sdio),
    .q_out(sdio_s)
  );

  assign last_bit = 7'({1'b0, CSP_HDR_BITS}) + 7'({1'b0, n_reg}) - 7'h01;
  assign next_bit = bit_reg + 7'h01;
  assign half_end = (div_reg == 8'(HALF - 1));
  assign fall_evt = (state_reg == CSP_H_SHIFT) && half_end && sclk_reg;
  assign busy_out = (state_reg != CSP_H_IDLE);
  assign link.sclk = sclk_reg;

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer and pins
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (!rst_n_in) begin
      state_reg <= CSP_H_IDLE;
      div_reg <= 8'h00;
      bit_reg <= 7'h00;
      sclk_reg <= 1'b0;
      link.cs_n <= 1'b1;
      link.host_sdio_out <= 1'b0;
      link.host_sdio_oe_n <= 1'b1;
      hdr_reg <= 8'h00;
      wd_reg <= '0;
      n_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        CSP_H_IDLE: begin
          if (start_in) begin
            hdr_reg <= {addr_in, read_in};
            wd_reg <= wdata_in;
            n_reg <= data_bits_in;
            link.cs_n <= 1'b0;
            link.host_sdio_out <= addr_in[CSP_ADDR_W-1];
            link.host_sdio_oe_n <= 1'b0;
            div_reg <= 8'h00;
            bit_reg <= 7'h00;
            state_reg <= CSP_H_SETUP;
          end
        end
        CSP_H_SETUP: begin
          if (half_end) begin
            div_reg <= 8'h00;
            state_reg <= CSP_H_SHIFT;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        CSP_H_SHIFT: begin
          if (half_end) begin
            div_reg <= 8'h00;
            sclk_reg <= !sclk_reg;
            if (sclk_reg) begin
              if (bit_reg == last_bit) begin
                link.host_sdio_oe_n <= 1'b1;
                state_reg <= CSP_H_HOLD;
              end else begin
                bit_reg <= next_bit;
                link.host_sdio_out <= tx_bit(hdr_reg, wd_reg, n_reg, next_bit);
                link.host_sdio_oe_n <= (hdr_reg[0] == CSP_DIR_READ) &&
                                       (next_bit >= 7'h08);
              end
            end
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
        CSP_H_HOLD: begin
          if (half_end) begin
            link.cs_n <= 1'b1;
          end
          if (div_reg == 8'(HOLD - 1)) begin
            div_reg <= 8'h00;
            done_out <= 1'b1;
            state_reg <= CSP_H_IDLE;
          end else begin
            div_reg <= div_reg + 8'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture at the end of each high phase, first 16 bits only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (fall_evt && (hdr_reg[0] == CSP_DIR_READ) && (bit_reg >= 7'h08) &&
                 (bit_reg < 7'h18)) begin
      rdata_out <= {rdata_out[CSP_DATA_W-2:0], sdio_s};
    end
  end

endmodule

// [tb/csp_link_asserts.sv]
`timescale 1ns/100ps
module csp_link_asserts (
  // system clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_out,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_out,
  input wire logic dev_sdio_oe_n
);
  ////////////////////////////////////////////////////////////////////////////
  // serial clock rises counted within a frame
  logic sclk_reg;
  logic [5:0] rise_cnt_reg;

  always_ff @(posedge clk_in) begin
    sclk_reg <= sclk;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cs_n) begin
      rise_cnt_reg <= 6'h00;
    end else if (sclk && !sclk_reg && rise_cnt_reg != 6'h3f) begin
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not low outside frame");
  a_no_contention: assert property (!(!host_sdio_oe_n && !dev_sdio_oe_n))
    else $error("both ends drive the data line");
  a_dev_release_cs: assert property (cs_n |-> dev_sdio_oe_n)
    else $error("device drives data line while deselected");
  a_host_data_held: assert property (
    (sclk && sclk_reg && !host_sdio_oe_n) |-> $stable(host_sdio_out))
    else $error("host data changed while serial clock high");
  a_dev_bit_stands: assert property (
    (sclk && sclk_reg && !dev_sdio_oe_n) |-> $stable(dev_sdio_out))
    else $error("device data changed while serial clock high");
  a_dev_drive_after_hdr: assert property (
    $fell(dev_sdio_oe_n) |-> (rise_cnt_reg == 6'h08) && host_sdio_oe_n)
    else $error("device drove before eight header bits");
  a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("select high gap too short");
  a_cs_setup_min: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("serial clock rose too soon after select");
  a_sclk_high_span: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase wrong length");
  a_frame_has_header: assert property ($rose(cs_n) |-> rise_cnt_reg >= 6'h08)
    else $error("frame ended before header complete");
endmodule

// [tb/config_serial_port_and_enable_gating_tb_top.sv]
`timescale 1ns/100ps
module config_serial_port_and_enable_gating_tb_top
  import csp_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start, read, fast_pin, poly, busy, done, clean;
  logic [6:0] addr;
  logic [15:0] wdata, rdata;
  logic [5:0] nbits;
  logic [10:0] block_en;
  logic [1:0] drv;
  csp_lo_rate_t rate;
  logic [3:0] bcin, bcout;
  logic [6:0] lres;
  logic [5:0] lcap;
  logic [31:0] wire_bits;
  int wire_cnt;
  int n_fail = 0;
  int n_checks = 0;
  logic [6:0] offs [5] = '{7'h01, 7'h10, 7'h22, 7'h30, 7'h31};
  logic [15:0] pat [5] = '{16'h0a5c, 16'h03c3, 16'h00a0, 16'h00c5, 16'h1a5c};

  always #50 clk_in = ~clk_in;

  csp_if link();

  csp_host #(.HALF(CSP_SCLK_HALF), .HOLD(CSP_HOLD_CYCLES)) i_csp_host (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .start_in(start),
    .read_in(read), .addr_in(addr), .wdata_in(wdata), .data_bits_in(nbits),
    .busy_out(busy), .done_out(done), .rdata_out(rdata));

  csp_device #(.NUM_BLOCKS(CSP_NUM_BLOCKS)) i_csp_device (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .fast_enable_pin_in(fast_pin),
    .polyphase_mode_in(poly), .block_en_out(block_en), .lo_out_drive_level_out(drv),
    .lo_output_pos_rate_out(rate), .lo_out_clean_single_out(clean),
    .balun_input_cap_sel_out(bcin), .balun_output_cap_sel_out(bcout),
    .linearity_resistor_sel_out(lres), .linearity_capacitor_sel_out(lcap));

  csp_link_asserts i_csp_link_asserts (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk(link.sclk), .cs_n(link.cs_n),
    .host_sdio_out(link.host_sdio_out), .host_sdio_oe_n(link.host_sdio_oe_n),
    .dev_sdio_out(link.dev_sdio_out), .dev_sdio_oe_n(link.dev_sdio_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  // wire monitor: bits as sampled by the device
  always @(negedge link.cs_n) begin
    wire_cnt = 0;
  end

  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      wire_bits = {wire_bits[30:0], link.sdio};
      wire_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one host transfer, judged on the wire and at the host
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                      input logic [5:0] n, input logic [15:0] exp);
    int i;
    @(posedge clk_in);
    start <= 1'b1;
    read <= rd;
    addr <= a;
    wdata <= wd;
    nbits <= n;
    @(posedge clk_in);
    start <= 1'b0;
    #1;
    chk(32'(busy), 32'h1);
    for (i = 0; i < 800; i++) begin
      @(posedge clk_in);
      #1;
      if (done === 1'b1) break;
    end
    chk(32'(i < 800), 32'h1);
    chk(32'(busy), 32'h0);
    chk(32'(wire_cnt), 32'(n) + 32'h8);
    if (rd) chk(32'(rdata), 32'(exp));
    if (n == 6'h10) chk(32'(wire_bits[23:0]), 32'({a, rd, rd ? exp : wd}));
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int k = 0; k < 5; k++) xfer(1'b1, offs[k], 16'h0000, 6'h10, 16'h0000);
    chk(32'(block_en), 32'h0);
    chk(32'({drv, rate, clean, bcin, bcout, lres, lcap}), 32'h0);
  endtask

  task automatic t_regs();
    for (int k = 0; k < 5; k++) xfer(1'b0, offs[k], pat[k], 6'h10, 16'h0000);
    for (int k = 0; k < 5; k++) xfer(1'b1, offs[k], 16'h0000, 6'h10, pat[k]);
    chk(32'({bcout, bcin}), 32'(pat[3][7:0]));
    chk(32'({lres, lcap}), 32'(pat[4][12:0]));
    xfer(1'b0, 7'h05, 16'hbeef, 6'h10, 16'h0000);
    xfer(1'b1, 7'h05, 16'h0000, 6'h10, 16'h0000);
    for (int c = 0; c < 3; c++) begin
      xfer(1'b0, 7'h22, {8'h00, 2'(c), 6'h00}, 6'h10, 16'h0000);
      settle();
      chk(32'(drv), 32'(c));
    end
  endtask

  task automatic t_partial();
    xfer(1'b0, 7'h30, 16'hffff, 6'h10, 16'h0000);
    xfer(1'b0, 7'h30, 16'h5000, 6'h04, 16'h0000);
    xfer(1'b1, 7'h30, 16'h0000, 6'h10, 16'h5fff);
    xfer(1'b0, 7'h30, 16'h1234, 6'h14, 16'h0000);
    xfer(1'b1, 7'h30, 16'h0000, 6'h10, 16'h1234);
    chk(32'({bcout, bcin}), 32'h34);
    // lowest band profile: input code 15, output code 3
    xfer(1'b0, 7'h30, 16'h003f, 6'h10, 16'h0000);
    settle();
    chk(32'({bcout, bcin}), 32'h3f);
  endtask

  task automatic t_gating();
    xfer(1'b0, 7'h01, 16'h0505, 6'h10, 16'h0000);
    xfer(1'b0, 7'h10, 16'h0704, 6'h10, 16'h0000);
    @(posedge clk_in);
    fast_pin <= 1'b0;
    settle();
    chk(32'(block_en), 32'h001);
    @(posedge clk_in);
    fast_pin <= 1'b1;
    settle();
    chk(32'(block_en), 32'h505);
  endtask

  task automatic t_lo();
    logic [15:0] en [6] = '{16'h0100, 16'h0100, 16'h0000, 16'h0080, 16'h0080, 16'h0080};
    logic [15:0] msk [6] = '{16'h0000, 16'h0000, 16'h0080, 16'h0000, 16'h0080, 16'h0000};
    logic [15:0] r22 [6] = '{16'h0020, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020};
    logic pm [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    csp_lo_rate_t er [6] = '{CSP_LO_SINGLE, CSP_LO_DOUBLE, CSP_LO_OFF, CSP_LO_OFF,
                             CSP_LO_SINGLE, CSP_LO_OFF};
    logic ec [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, 7'h01, en[k], 6'h10, 16'h0000);
      xfer(1'b0, 7'h10, msk[k], 6'h10, 16'h0000);
      xfer(1'b0, 7'h22, r22[k], 6'h10, 16'h0000);
      @(posedge clk_in);
      poly <= pm[k];
      settle();
      chk(32'(rate), 32'(er[k]));
      chk(32'(clean), 32'(ec[k]));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    start <= 1'b0;
    read <= 1'b0;
    addr <= 7'h00;
    wdata <= 16'h0000;
    nbits <= 6'h10;
    fast_pin <= 1'b0;
    poly <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_regs();
    t_partial();
    t_gating();
    t_lo();
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    give_verdict();
  end
endmodule
